// ---- rtl/fmt_aux_ctrl.sv ----
// Auxiliary formatter control: capture, measurement routing, clock-generator mode and resets.
`timescale 1ns/100ps
`default_nettype none
module fmt_aux_ctrl
  import fmt_aux_pkg::*;
#(
  parameter int NCH = NUM_CH,  // Channel count.
  parameter int PW  = PAT_W    // Pattern and delay width.
) (
  input  wire logic                  clk_sys,             // Master clock.
  input  wire logic                  rst,                 // Asynchronous hard reset, active high.
  input  wire logic                  csr_wr,              // Register write strobe.
  input  wire logic [CSR_ADDR_W-1:0] csr_addr,            // Register address.
  input  wire logic [CSR_DATA_W-1:0] csr_wdata,           // Register write data.
  output logic      [CSR_DATA_W-1:0] csr_rdata,           // Register read data.
  input  wire logic [NCH-1:0]        comp_hi,             // High comparator of each pin.
  input  wire logic [NCH-1:0]        comp_lo,             // Low comparator of each pin.
  input  wire logic [NCH*4-1:0]      compare_strobe,      // Compare event strobes, 4 per pin.
  input  wire logic [NCH*4*3-1:0]    capture_sel,         // Per output: event(2) and level(1).
  output logic      [NCH*4-1:0]      capture_out,         // Captured samples, 4 per pin.
  input  wire logic [2:0]            meas_arm_sel,        // Source of arm: pin*2+level.
  input  wire logic [2:0]            meas_begin_sel,      // Source of start.
  input  wire logic [2:0]            meas_end_sel,        // Source of stop.
  input  wire logic                  meas_drive_en,       // Drive the measurement bus.
  output logic                       meas_arm_out,        // Arm signal.
  output logic                       meas_begin_out,      // Start signal.
  output logic                       meas_end_out,        // Stop signal.
  output logic                       meas_oe,             // Measurement output enable.
  input  wire logic [3:2]            lj_clk_sel,          // Pass the low-jitter clock on ch3/ch2.
  input  wire logic                  lj_clk,              // External low-jitter clock, resampled.
  input  wire logic [NCH-1:0]        fmt_drive_data,      // Formatted drive data per channel.
  output logic                       drive_data_ch3,      // Drive data channel 3.
  output logic                       drive_data_ch2,      // Drive data channel 2.
  output logic      [1:0]            drive_data_lo,       // Drive data channels 1 and 0.
  input  wire logic                  clockgen_mode_enable, // Clock-generator mode request.
  input  wire logic                  period_start_early,  // Shared period start.
  input  wire logic                  pattern_valid,       // Pattern word qualifier.
  input  wire logic [NCH*PW-1:0]     pattern_word,        // Pattern data per channel.
  input  wire logic [PW-1:0]         input_delay,         // Shared input delay.
  input  wire logic [NUM_EDGE-1:0]   edge_fail_mask,      // Fail mask per edge.
  output logic                       clockgen_active,     // Clock-generator mode in force.
  output logic      [NCH-1:0]        ch_period_start,     // Period start per channel.
  output logic      [NCH*PW-1:0]     ch_wave_sel,         // Waveform address per channel.
  output logic      [NCH*PW-1:0]     ch_delay,            // Input delay per channel.
  output logic      [NCH-1:0]        ch_pat_load,         // Pattern load enable per channel.
  output logic      [NUM_EDGE-1:0]   fail_mask_eff,       // Mask applied to accumulation.
  output logic                       soft_reset,          // Register initialise pulse.
  output logic                       err_fifo_reset,      // Error and FIFO reset pulse.
  output logic                       core_rst             // Synchronised reset for the core.
);

  // All module state except the reset synchroniser in one packed record.
  typedef struct packed {
    logic [NCH*4-1:0]      cap_hi;     // High samples taken on events.
    logic [NCH*4-1:0]      cap_lo;     // Low samples taken on events.
    logic [NCH*4-1:0]      cap_out;    // Capture outputs aligned to the tick.
    logic                  arm;        // Registered arm.
    logic                  beg;        // Registered start.
    logic                  fin;        // Registered stop.
    logic                  oe;         // Registered bus enable.
    logic [2:0]            lj_sync;    // Three-stage sampler of the external clock.
    logic                  lj_state;   // Accepted external clock level.
    logic [NCH-1:0]        drv;        // Registered drive data.
    logic                  cg_en;      // Sampled mode enable.
    logic                  cg_act;     // Clock-generator mode active.
    logic [NCH-1:0]        pstart;     // Period start per channel.
    logic [NCH*PW-1:0]     wsel;       // Waveform selection per channel.
    logic [NCH*PW-1:0]     dly;        // Delay per channel.
    logic [NCH-1:0]        load;       // Pattern load per channel.
    logic [NUM_EDGE-1:0]   fmask;      // Effective fail mask.
    logic [CSR_DATA_W-1:0] rctl;       // reset_control register.
    logic [CSR_DATA_W-1:0] rdata;      // Read data.
    logic                  srst;       // Soft reset pulse.
    logic                  erst;       // Error reset pulse.
  } state_t;

  state_t r;    // Registered state.
  state_t nxt;  // Next state.

  logic [1:0] rst_sync_r;  // Reset release synchroniser.
  logic [2*NCH-1:0] comp_vec;  // Comparators interleaved: pin*2 + level(1=low).
  logic meas_arm_mux;    // Arm selector output.
  logic meas_begin_mux;  // Start selector output.
  logic meas_end_mux;    // Stop selector output.

  // The reset is asserted at once but released only after two clock edges.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rst_sync_r <= 2'h3;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b0};
    end
  end

  // Comparator vector so any pin and level can be picked by one index.
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_cv
      assign comp_vec[2*gi]   = comp_hi[gi];
      assign comp_vec[2*gi+1] = comp_lo[gi];
    end
  endgenerate

  // Three independent selectors, one per measurement signal.
  fmt_sel_mux #(.SRC_W(2*NCH), .SEL_W(3)) u_arm (
    .src (comp_vec),
    .sel (meas_arm_sel),
    .q   (meas_arm_mux)
  );
  fmt_sel_mux #(.SRC_W(2*NCH), .SEL_W(3)) u_begin (
    .src (comp_vec),
    .sel (meas_begin_sel),
    .q   (meas_begin_mux)
  );
  fmt_sel_mux #(.SRC_W(2*NCH), .SEL_W(3)) u_end (
    .src (comp_vec),
    .sel (meas_end_sel),
    .q   (meas_end_mux)
  );

  // Next-state logic for every function of the block except the reset synchroniser.
  always_comb begin
    int ev;
    ev  = 0;
    nxt = r;
    // Samples are caught on each event and held until the tick publishes them.
    for (int c = 0; c < NCH; c++) begin
      for (int e = 0; e < 4; e++) begin
        if (compare_strobe[c*4+e]) begin
          nxt.cap_hi[c*4+e] = comp_hi[c];
          nxt.cap_lo[c*4+e] = comp_lo[c];
        end
      end
    end
    // Each capture output picks an event and a level; the tick retimes it.
    if (period_start_early) begin
      for (int c = 0; c < NCH; c++) begin
        for (int k = 0; k < 4; k++) begin
          ev = c*4 + int'(capture_sel[(c*4+k)*3 +: 2]);
          nxt.cap_out[c*4+k] = capture_sel[(c*4+k)*3+2] ? r.cap_lo[ev]
                                                        : r.cap_hi[ev];
        end
      end
    end
    // Measurement outputs are registered; the enable releases the shared bus.
    nxt.arm = meas_arm_mux;
    nxt.beg = meas_begin_mux;
    nxt.fin = meas_end_mux;
    nxt.oe  = meas_drive_en;
    // The pin clock is resampled; a change counts once two stages agree.
    nxt.lj_sync = {r.lj_sync[1:0], lj_clk};
    if (r.lj_sync[2] == r.lj_sync[1]) begin
      nxt.lj_state = r.lj_sync[2];
    end
    // Only the upper two channels have the clock selector.
    nxt.drv = fmt_drive_data;
    nxt.drv[3] = lj_clk_sel[3] ? r.lj_state : fmt_drive_data[3];
    nxt.drv[2] = lj_clk_sel[2] ? r.lj_state : fmt_drive_data[2];
    // The mode request is taken on the clock so the remap switches cleanly.
    nxt.cg_en  = clockgen_mode_enable;
    nxt.cg_act = r.cg_en & period_start_early;
    // Input remapping per mode.
    for (int c = 0; c < NCH; c++) begin
      if (r.cg_act) begin
        nxt.pstart[c]        = edge_fail_mask[c];
        nxt.wsel[c*PW +: PW] = '0;
        nxt.dly[c*PW +: PW]  = pattern_word[c*PW +: PW];
        nxt.load[c]          = 1'b1;
      end else begin
        nxt.pstart[c]        = period_start_early;
        nxt.wsel[c*PW +: PW] = pattern_word[c*PW +: PW];
        nxt.dly[c*PW +: PW]  = input_delay;
        nxt.load[c]          = pattern_valid;
      end
    end
    nxt.fmask = r.cg_act ? '0 : edge_fail_mask;
    // Reset control bits act as one-cycle pulses and clear themselves.
    nxt.srst = 1'b0;
    nxt.erst = 1'b0;
    nxt.rctl = '0;
    // Soft reset returns reset_control to its reset value but leaves the FIFO path alone.
    // It is applied before the write decode so that a write in the same cycle wins.
    if (r.srst) begin
      nxt.rctl = RESET_CTRL_RST;
    end
    if (csr_wr && csr_addr == RESET_CTRL_ADDR) begin
      nxt.rctl = csr_wdata & RESET_CTRL_WMASK;
      nxt.srst = csr_wdata[SOFT_RST_BIT];
      nxt.erst = csr_wdata[ERR_RST_BIT];
    end
    // Read data shows the reset control; every other address reads zero.
    nxt.rdata = '0;
    if (csr_addr == RESET_CTRL_ADDR) begin
      nxt.rdata = r.rctl;
    end
  end

  // State register; the core reset is the synchronised release.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign csr_rdata       = r.rdata;
  assign capture_out     = r.cap_out;
  assign meas_arm_out    = r.arm;
  assign meas_begin_out  = r.beg;
  assign meas_end_out    = r.fin;
  assign meas_oe         = r.oe;
  assign drive_data_ch3  = r.drv[3];
  assign drive_data_ch2  = r.drv[2];
  assign drive_data_lo   = r.drv[1:0];
  assign clockgen_active = r.cg_act;
  assign ch_period_start = r.pstart;
  assign ch_wave_sel     = r.wsel;
  assign ch_delay        = r.dly;
  assign ch_pat_load     = r.load;
  assign fail_mask_eff   = r.fmask;
  assign soft_reset      = r.srst;
  assign err_fifo_reset  = r.erst;
  assign core_rst        = rst_sync_r[1];

  // Mode becomes active one cycle after enable and period start were seen.
  property p_cg_act;
    @(posedge clk_sys) disable iff (rst)
      $past(r.cg_en) && $past(period_start_early) |-> clockgen_active;
  endproperty
  a_cg_act: assert property (p_cg_act) else $error("clockgen mode not entered");

  // No masking while clock-generator mode holds.
  property p_no_mask;
    @(posedge clk_sys) disable iff (rst)
      $past(clockgen_active) |-> fail_mask_eff == '0;
  endproperty
  a_no_mask: assert property (p_no_mask) else $error("mask in clockgen mode");

  // Waveform selection is zero in clock-generator mode.
  property p_wsel_zero;
    @(posedge clk_sys) disable iff (rst)
      $past(clockgen_active) |-> ch_wave_sel == '0;
  endproperty
  a_wsel_zero: assert property (p_wsel_zero) else $error("waveform not at zero");

  // Channel period start follows its mask bit in clock-generator mode.
  property p_cg_start;
    @(posedge clk_sys) disable iff (rst)
      $past(clockgen_active) |-> ch_period_start == $past(edge_fail_mask);
  endproperty
  a_cg_start: assert property (p_cg_start) else $error("period start remap wrong");

  // Normal mode uses the shared delay, checked on channel 0.
  property p_norm_dly;
    @(posedge clk_sys) disable iff (rst)
      !$past(rst) && !$past(clockgen_active) |-> ch_delay[PW-1:0] == $past(input_delay);
  endproperty
  a_norm_dly: assert property (p_norm_dly) else $error("shared delay not used");

  // Normal mode mask follows the input mask.
  property p_norm_mask;
    @(posedge clk_sys) disable iff (rst)
      !$past(rst) && !$past(clockgen_active) |-> fail_mask_eff == $past(edge_fail_mask);
  endproperty
  a_norm_mask: assert property (p_norm_mask) else $error("mask not applied");

  // A write of bit 3 gives a reset pulse in the next cycle.
  property p_err_rst;
    @(posedge clk_sys) disable iff (rst)
      csr_wr && csr_addr == RESET_CTRL_ADDR && csr_wdata[ERR_RST_BIT]
      |=> err_fifo_reset;
  endproperty
  a_err_rst: assert property (p_err_rst) else $error("error reset pulse wrong");

  // Without such a write the pulse stays low, so back-to-back writes give one each.
  property p_err_only;
    @(posedge clk_sys) disable iff (rst)
      !(csr_wr && csr_addr == RESET_CTRL_ADDR && csr_wdata[ERR_RST_BIT])
      |=> !err_fifo_reset;
  endproperty
  a_err_only: assert property (p_err_only) else $error("stray error reset pulse");

  // Soft reset pulse follows a write of bit 0.
  property p_soft_rst;
    @(posedge clk_sys) disable iff (rst)
      csr_wr && csr_addr == RESET_CTRL_ADDR && csr_wdata[SOFT_RST_BIT] |=> soft_reset;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset missing");

  // Core reset stays asserted for two edges after release.
  property p_rst_rel;
    @(posedge clk_sys) $fell(rst) |-> core_rst;
  endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("reset released early");

  // The core reset drops on the second edge after release and not later.
  property p_rst_done;
    @(posedge clk_sys) disable iff (rst)
      $fell(rst) |-> core_rst ##1 core_rst ##1 !core_rst;
  endproperty
  a_rst_done: assert property (p_rst_done) else $error("core reset release wrong");

  // Measurement enable follows its request one cycle later.
  property p_meas_oe;
    @(posedge clk_sys) disable iff (rst)
      meas_drive_en |=> meas_oe;
  endproperty
  a_meas_oe: assert property (p_meas_oe) else $error("bus enable lost");

  // Dropping the request releases the shared bus one cycle later.
  property p_meas_rel;
    @(posedge clk_sys) disable iff (rst)
      !meas_drive_en |=> !meas_oe;
  endproperty
  a_meas_rel: assert property (p_meas_rel) else $error("bus not released");

  // The arm output carries the selected comparator one cycle later.
  property p_meas_route;
    @(posedge clk_sys) disable iff (rst)
      !$past(rst) |-> meas_arm_out == $past(comp_vec[meas_arm_sel]);
  endproperty
  a_meas_route: assert property (p_meas_route) else $error("arm routing wrong");

endmodule : fmt_aux_ctrl
`default_nettype wire

// ---- rtl/fmt_aux_pkg.sv ----
// Package with register layout, reset values and timing constants of the formatter aux block.
package fmt_aux_pkg;
  localparam int          NUM_CH          = 4;     // Channels in the device.
  localparam int          NUM_EDGE        = 4;     // Compare events per channel.
  localparam int          PAT_W           = 8;     // Pattern word and input delay width.
  localparam int          CSR_ADDR_W      = 5;     // Register address width.
  localparam int          CSR_DATA_W      = 16;    // Register data width.
  localparam logic [4:0]  RESET_CTRL_ADDR = 5'h19; // Address of reset_control.
  localparam int          SOFT_RST_BIT    = 0;     // Soft reset bit position.
  localparam int          ERR_RST_BIT     = 3;     // Error and FIFO reset bit position.
  localparam logic [15:0] RESET_CTRL_RST  = 16'h0000; // Reset value of reset_control.
  localparam logic [15:0] RESET_CTRL_WMASK = 16'h0009; // Implemented bits of reset_control.
  localparam int          CLK_MHZ         = 20;    // Master clock rate.
  localparam int          HARD_RST_US     = 20;    // Least hold of the hard reset after clock is stable.
  localparam int          HARD_RST_CYC    = HARD_RST_US * CLK_MHZ; // Cycles of that hold.
  localparam int          MIN_RST_PULSE   = 3;     // Least hard reset pulse in clock periods.
endpackage : fmt_aux_pkg

// ---- rtl/fmt_sel_mux.sv ----
// Selector that picks one bit of a source vector by an index.
`timescale 1ns/100ps
`default_nettype none
module fmt_sel_mux #(
  parameter int SRC_W = 8,  // Number of selectable sources.
  parameter int SEL_W = 3   // Width of the index.
) (
  input  wire logic [SRC_W-1:0] src,  // Candidate bits.
  input  wire logic [SEL_W-1:0] sel,  // Index of the bit to pass.
  output logic                  q     // Selected bit.
);
  // An index beyond the source list yields zero rather than an unknown.
  always_comb begin
    q = 1'b0;
    if (32'(sel) < SRC_W) begin
      q = src[sel];
    end
  end
endmodule : fmt_sel_mux
`default_nettype wire

// ---- tb/fmt_far_model.sv ----
// Far-side model: pin comparator chips and the shared measurement bus selector.
`timescale 1ns/100ps
`default_nettype none
module fmt_far_model (
  input  wire logic       clk_sys,  // Master clock.
  input  wire logic [3:0] lvl_hi,   // Wanted high comparator levels.
  input  wire logic [3:0] lvl_lo,   // Wanted low comparator levels.
  input  wire logic       meas_oe,  // Device drives the measurement bus.
  input  wire logic       meas_arm, // Arm from the device.
  output logic      [3:0] comp_hi,  // High comparator outputs.
  output logic      [3:0] comp_lo,  // Low comparator outputs.
  output logic            bus_arm   // Arm as seen by the measurement unit.
);
  logic last_r; // Last level the device drove.
  // Comparators settle just after the edge, like a real pin chip.
  always_ff @(posedge clk_sys) begin
    comp_hi <= lvl_hi;
    comp_lo <= lvl_lo;
  end
  // The selector passes the arm only while the device drives it; an undriven bus
  // has no pull, so it shows the inverse of its last level to expose stale reads.
  always_ff @(posedge clk_sys) begin
    if (meas_oe) begin
      last_r  <= meas_arm;
      bus_arm <= meas_arm;
    end else begin
      bus_arm <= ~last_r;
    end
  end
endmodule : fmt_far_model
`default_nettype wire

// ---- tb/formatter_mode_capture_reset_bench.sv ----
// Self-checking bench for the formatter aux control block.
`timescale 1ns/100ps
`default_nettype none
module formatter_mode_capture_reset_bench;
  import fmt_aux_pkg::*;
  // One row: mode inputs, then the outputs they should give.
  typedef struct packed {
    logic en; logic ps; logic vld; logic [31:0] pw; logic [7:0] dly; logic [3:0] msk;
    logic act; logic [3:0] pso; logic [31:0] wave; logic [31:0] cdly;
    logic [3:0] ld; logic [3:0] fm;
  } row_t;
  localparam logic [31:0] PW = 32'hA1B2C3D4; // Pattern word used by all rows.
  localparam logic [31:0] DR = 32'h5E5E5E5E; // Shared delay seen on every channel.
  row_t rows [4] = '{
    '{1'b0, 1'b1, 1'b1, PW, 8'h5E, 4'h5, 1'b0, 4'hF, PW, DR, 4'hF, 4'h5},
    '{1'b0, 1'b0, 1'b0, PW, 8'h5E, 4'hA, 1'b0, 4'h0, PW, DR, 4'h0, 4'hA},
    '{1'b1, 1'b1, 1'b0, PW, 8'h5E, 4'h6, 1'b1, 4'h6, 32'h0, PW, 4'hF, 4'h0},
    '{1'b1, 1'b0, 1'b1, PW, 8'h5E, 4'h3, 1'b0, 4'h0, PW, DR, 4'hF, 4'h3}};
  logic        clk_sys, rst, csr_wr, meas_drive_en, lj_clk, bus_arm;
  logic        clockgen_mode_enable, period_start_early, pattern_valid;
  logic        meas_arm_out, meas_begin_out, meas_end_out, meas_oe;
  logic        drive_data_ch3, drive_data_ch2, clockgen_active;
  logic        soft_reset, err_fifo_reset, core_rst;
  logic [4:0]  csr_addr;
  logic [15:0] csr_wdata, csr_rdata, compare_strobe, capture_out;
  logic [3:0]  lvl_hi, lvl_lo, comp_hi, comp_lo, fmt_drive_data, edge_fail_mask;
  logic [3:0]  ch_period_start, ch_pat_load, fail_mask_eff;
  logic [47:0] capture_sel;
  logic [2:0]  meas_arm_sel, meas_begin_sel, meas_end_sel;
  logic [3:2]  lj_clk_sel;
  logic [1:0]  drive_data_lo;
  logic [31:0] pattern_word, ch_wave_sel, ch_delay;
  logic [7:0]  input_delay;
  int          err_total, total_checks;
  fmt_aux_ctrl DUT (.*);
  fmt_far_model far (.clk_sys(clk_sys), .lvl_hi(lvl_hi), .lvl_lo(lvl_lo), .meas_oe(meas_oe),
    .meas_arm(meas_arm_out), .comp_hi(comp_hi), .comp_lo(comp_lo), .bus_arm(bus_arm));
  // Free-running 20 MHz master clock.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Raises a write for one cycle; the caller lowers it, so writes may run back to back.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    csr_wr <= 1'b1;
    csr_addr <= a;
    csr_wdata <= d;
  endtask : wr
  // Ends a write burst and waits a cycle with a given address on the bus.
  task automatic idle(input logic [4:0] a);
    @(posedge clk_sys);
    csr_wr <= 1'b0;
    csr_addr <= a;
  endtask : idle
  // Waits n edges, then steps to the settled falling edge.
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle
  // Prints the verdict and ends the run.
  task automatic final_report();
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  // Main sequence.
  initial begin
    {rst, csr_wr, csr_addr, csr_wdata, compare_strobe, capture_sel} = '0;
    {meas_arm_sel, meas_begin_sel, meas_end_sel, meas_drive_en, lj_clk_sel, lj_clk} = '0;
    {fmt_drive_data, clockgen_mode_enable, period_start_early, pattern_valid} = '0;
    {pattern_word, input_delay, edge_fail_mask, lvl_hi, lvl_lo} = '0;
    err_total = 0;
    total_checks = 0;
    rst = 1'b1; // Hold well past three clocks while the clock settles.
    settle(20);
    chk(core_rst, 1'b1);
    chk({capture_out, meas_oe, soft_reset, err_fifo_reset}, '0);
    @(posedge clk_sys);
    rst <= 1'b0;
    settle(3);
    chk(core_rst, 1'b0);
    // Error and FIFO reset first, then a soft reset right behind it.
    wr(RESET_CTRL_ADDR, 16'h0008);
    wr(RESET_CTRL_ADDR, 16'h0001);
    @(negedge clk_sys);
    chk({soft_reset, err_fifo_reset}, 2'b01);
    idle(RESET_CTRL_ADDR);
    @(negedge clk_sys);
    chk({soft_reset, err_fifo_reset}, 2'b10);
    settle(1);
    chk(csr_rdata, 16'h0001);
    settle(1);
    chk({csr_rdata, soft_reset, err_fifo_reset}, '0);
    wr(5'h18, 16'h0009);
    idle(5'h03);
    @(negedge clk_sys);
    chk({soft_reset, err_fifo_reset}, 2'b00);
    settle(1);
    chk(csr_rdata, 16'h0000);
    // Mode table: each row is held still, then the mapped outputs compared.
    foreach (rows[i]) begin
      @(posedge clk_sys);
      clockgen_mode_enable <= rows[i].en;
      period_start_early <= rows[i].ps;
      pattern_valid <= rows[i].vld;
      pattern_word <= rows[i].pw;
      input_delay <= rows[i].dly;
      edge_fail_mask <= rows[i].msk;
      settle(3);
      chk(clockgen_active, rows[i].act);
      chk(ch_period_start, rows[i].pso);
      chk(ch_wave_sel, rows[i].wave);
      chk(ch_delay, rows[i].cdly);
      chk(ch_pat_load, rows[i].ld);
      chk(fail_mask_eff, rows[i].fm);
    end
    // Measurement routing: every source index reaches every output.
    @(posedge clk_sys);
    lvl_hi <= 4'h5;
    lvl_lo <= 4'h3;
    meas_drive_en <= 1'b1;
    clockgen_mode_enable <= 1'b0;
    period_start_early <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      meas_arm_sel <= 3'(i);
      meas_begin_sel <= 3'(7 - i);
      meas_end_sel <= 3'(i + 3);
      settle(4);
      chk(meas_arm_out, i[0] ? lvl_lo[i/2] : lvl_hi[i/2]);
      chk(meas_begin_out, i[0] ? lvl_hi[(7-i)/2] : lvl_lo[(7-i)/2]);
      chk(meas_end_out, (i % 2 == 0) ? lvl_lo[((i+3)%8)/2] : lvl_hi[((i+3)%8)/2]);
      chk({meas_oe, bus_arm}, {1'b1, i[0] ? lvl_lo[i/2] : lvl_hi[i/2]});
    end
    // Releasing the bus lets another device take it; the last source was pin 3 low.
    @(posedge clk_sys);
    meas_drive_en <= 1'b0;
    settle(3);
    chk({meas_oe, bus_arm}, {1'b0, ~lvl_lo[3]});
    // Capture: strobe event 2 of pin 0, then a period tick presents it.
    @(posedge clk_sys);
    capture_sel[11:0] <= 12'h156;
    lvl_hi <= 4'h1;
    lvl_lo <= 4'h0;
    settle(2);
    @(posedge clk_sys);
    compare_strobe <= 16'h0004;
    @(posedge clk_sys);
    compare_strobe <= 16'h0000;
    period_start_early <= 1'b1;
    @(posedge clk_sys);
    period_start_early <= 1'b0;
    settle(3);
    chk(capture_out[3:0], 4'b0010);
    // Low-jitter clock selector on channels 3 and 2 only.
    @(posedge clk_sys);
    fmt_drive_data <= 4'b1010;
    lj_clk_sel <= 2'b01;
    lj_clk <= 1'b1;
    settle(6);
    chk({drive_data_ch3, drive_data_ch2, drive_data_lo}, 4'b1110);
    @(posedge clk_sys);
    lj_clk_sel <= 2'b10;
    lj_clk <= 1'b0;
    settle(6);
    chk({drive_data_ch3, drive_data_ch2, drive_data_lo}, 4'b0010);
    // A second hard reset held the full settle time, then soft and error resets.
    @(posedge clk_sys);
    rst <= 1'b1;
    settle(HARD_RST_CYC);
    chk({core_rst, capture_out, meas_oe, drive_data_ch3}, 32'h00040000);
    @(posedge clk_sys);
    rst <= 1'b0;
    settle(3);
    chk(core_rst, 1'b0);
    wr(RESET_CTRL_ADDR, 16'h0001);
    wr(RESET_CTRL_ADDR, 16'h0008);
    idle(RESET_CTRL_ADDR);
    @(negedge clk_sys);
    chk({soft_reset, err_fifo_reset}, 2'b01);
    settle(1);
    chk(csr_rdata, 16'h0008);
    final_report();
  end
endmodule : formatter_mode_capture_reset_bench
`default_nettype wire
